// File: ivr_controller.sv
// Purpose: Nested vectored interrupt logic with source routing
// Assumes: Core answers with stack_done, handler_return, unstack_done
// Notes:   Configuration arrives on plain input ports
// How it works
// (RL1) Sixteen system exceptions and 32 peripheral inputs, each with a table entry.
// (RL2) Word 0x00 gives initial stack pointer; exception n uses offset 4n.
// (RL3) Reset, NMI, hard fault fixed at -3,-2,-1; blocked faults escalate.
// (RL4) Exceptions 16..47 are interrupts 0..31 at offsets 0x40..0xBC.
// (RL5) Software sets bit 0 of every table vector to one.
// (RL6) NMI comes from any selected pin or is disconnected.
// (RL7) Each interrupt has one of eight levels, changeable at any time.
// (RL8) Grouping splits level into preempting part and ordering part.
// (RL9) Tail-chain on return with pending work; better arrival takes over entry.
// (RL10) State saved on entry and restored on exit by hardware.
// (RL11) Equal levels resolve to the lower vector number.
// (RL12) Each vector takes exactly one of fixed, DMA or fabric sources.
// (RL13) DMA vectors 0..15 use low bus, 16..31 use high bus.
// (RL14) Fabric source for vector n is fabric bus bit n.
// (RL15) Fabric path lets any source reach any vector.
// (RL16) Fixed lines: droop, cache, sleep, port units, comparators, caps, I2C, CAN, timers.
// (RL17) Fixed lines 21..31 USB, display, filter, decimator, hub, EEPROM; 2, 26 reserved.
// (RL18) Per-vector writable select; only the selected line sets pending.

`timescale 1ns/1ps
`default_nettype none

module ivr_controller
    import ivr_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           resetn,
    input  wire logic [NUM_IRQ-1:0]             fixed_irq,
    input  wire logic [15:0]                    dma_term_out_low,
    input  wire logic [15:0]                    dma_term_out_high,
    input  wire logic [NUM_IRQ-1:0]             fabric_irq,
    input  wire logic [NUM_IRQ-1:0][1:0]        irq_src_sel,
    input  wire logic [NUM_IRQ-1:0][LVL_W-1:0]  irq_level,
    input  wire logic [NUM_IRQ-1:0]             irq_enable,
    input  wire logic [NUM_SYS-1:0][LVL_W-1:0]  sys_level,
    input  wire logic [1:0]                     prio_split,
    input  wire logic                           irq_mask,
    input  wire logic [NMI_PIN_W-1:0]           nmi_pins,
    input  wire logic [5:0]                     nmi_pin_sel,
    input  wire logic                           nmi_connect,
    input  wire logic [2:0]                     fault_req,
    input  wire logic [2:0]                     fault_enable,
    input  wire logic [3:0]                     sys_req,
    input  wire logic                           stack_done,
    input  wire logic                           handler_return,
    input  wire logic                           unstack_done,
    output ivr_vec_t                            vec,
    output ivr_cmd_t                            cmd,
    output logic [3:0]                          nest_depth
);

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    ivr_state_t                 state;
    ivr_state_t                 next_state;
    ivr_vec_t                   next_vec;
    ivr_cmd_t                   next_cmd;
    ivr_key_t [NUM_EXC-1:0]     key;
    logic [NUM_EXC-1:0]         pending;
    logic [NUM_EXC-1:0]         set_vec;
    logic [NUM_EXC-1:0]         clr_vec;
    logic [NUM_EXC-1:0]         allowed;
    logic [NUM_IRQ-1:0]         routed;
    logic [NUM_IRQ-1:0]         ff_line;
    logic [NUM_IRQ-1:0]         dma_bus;
    logic [5:0]                 stack [STACK_DEPTH];
    logic [3:0]                 depth;
    logic [5:0]                 cur_num;
    logic [5:0]                 prev_num;
    logic [4:0]                 run_grp;
    logic [4:0]                 ret_grp;
    logic [2:0]                 esc;
    logic                       nmi_line;
    logic                       cand_found;
    logic [5:0]                 cand_num;
    ivr_key_t                   cand_key;
    logic                       preempt;
    logic                       push;
    logic                       pop;
    logic [5:0]                 push_num;

    // ------------------------------------------------------------
    // Source routing
    // ------------------------------------------------------------
    assign ff_line  = fixed_irq & ~FF_RESERVED;                 // see (RL16) see (RL17)
    assign dma_bus  = {dma_term_out_high, dma_term_out_low};    // see (RL13)
    assign nmi_line = nmi_connect & nmi_pins[nmi_pin_sel];      // see (RL6)

    for (genvar n = 0; n < NUM_IRQ; n++) begin : g_route
        ivr_src_sel u_sel (                                     // see (RL12) see (RL18)
            .sel         (ivr_src_t'(irq_src_sel[n])),
            .fixed_line  (ff_line[n]),
            .dma_line    (dma_bus[n]),
            .fabric_line (fabric_irq[n]),                       // see (RL14) see (RL15)
            .req         (routed[n])
        );

        a_route_source: assert property ( // see (RL12) see (RL13) see (RL14)
            routed[n] == ((irq_src_sel[n] == SRC_DMA) ? dma_bus[n] :
                          (irq_src_sel[n] == SRC_FABRIC) ? fabric_irq[n] : ff_line[n]))
            else $error("Vector request does not follow its selected source");

        a_route_pend: assert property ( // see (RL18)
            routed[n] |=> pending[NUM_SYS+n])
            else $error("Selected line did not set its pending bit");
    end

    // ------------------------------------------------------------
    // Priority keys
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_EXC; i++) begin
            key[i] = '{grp: KEY_THREAD, sub: 3'h7};
        end
        key[EXC_RESET] = '{grp: KEY_RESET, sub: 3'h0};          // see (RL3)
        key[EXC_NMI]   = '{grp: KEY_NMI, sub: 3'h0};
        key[EXC_HARD]  = '{grp: KEY_HARD, sub: 3'h0};
        for (int i = 4; i < NUM_SYS; i++) begin
            key[i] = prog_key(sys_level[i], prio_split);
        end
        for (int n = 0; n < NUM_IRQ; n++) begin
            key[NUM_SYS+n] = prog_key(irq_level[n], prio_split); // see (RL4) see (RL7) see (RL8)
        end
    end

    // ------------------------------------------------------------
    // Nesting stack view
    // ------------------------------------------------------------
    assign cur_num  = (depth != 4'h0) ? stack[depth-4'h1] : 6'h00;
    assign prev_num = (depth > 4'h1) ? stack[depth-4'h2] : 6'h00;
    assign run_grp  = (depth != 4'h0) ? key[cur_num].grp : KEY_THREAD;
    assign ret_grp  = (depth > 4'h1) ? key[prev_num].grp : KEY_THREAD;
    assign nest_depth = depth;

    // ------------------------------------------------------------
    // Pending set and take permission
    // ------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        esc     = 3'h0;
        set_vec[EXC_NMI] = nmi_line;
        for (int f = 0; f < 3; f++) begin
            esc[f] = !fault_enable[f] || irq_mask ||
                     key[int'(EXC_MEM)+f].grp >= run_grp;        // see (RL3)
            if (fault_req[f]) begin
                if (esc[f]) begin
                    set_vec[EXC_HARD] = 1'b1;
                end else begin
                    set_vec[int'(EXC_MEM)+f] = 1'b1;
                end
            end
        end
        set_vec[EXC_SVC]     = sys_req[0];
        set_vec[EXC_DEBUG]   = sys_req[1];
        set_vec[EXC_PENDSV]  = sys_req[2];
        set_vec[EXC_SYSTICK] = sys_req[3];
        set_vec[NUM_EXC-1:NUM_SYS] = routed;                    // see (RL1) see (RL4)
    end

    assign allowed = {irq_enable & {NUM_IRQ{~irq_mask}},
                      (SYS_PROG_MASK & {NUM_SYS{~irq_mask}}) | SYS_ALWAYS};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pending <= '0;
        end else begin
            pending <= (pending & ~clr_vec) | set_vec;
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    ivr_pick u_pick (
        .clk    (clk),
        .resetn (resetn),
        .req    (pending & allowed),
        .key    (key),
        .found  (cand_found),
        .num    (cand_num),
        .best   (cand_key)
    );

    assign preempt = cand_found && cand_key.grp < run_grp;      // see (RL8)

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_vec   = vec;
        next_cmd   = '0;
        clr_vec    = '0;
        push       = 1'b0;
        pop        = 1'b0;
        push_num   = vec.num;
        case (state)
            ST_BOOT_SP: begin
                next_vec       = '{num: 6'h00, offset: OFS_INIT_SP}; // see (RL2)
                next_cmd.fetch = 1'b1;
                next_state     = ST_BOOT_PC;
            end
            ST_BOOT_PC: begin
                next_vec       = '{num: EXC_RESET, offset: OFS_RESET};
                next_cmd.fetch = 1'b1;
                next_cmd.go    = 1'b1;
                next_state     = ST_RUN;
            end
            ST_RUN: begin
                if (handler_return && depth != 4'h0) begin
                    pop = 1'b1;
                    if (cand_found && cand_key.grp < ret_grp) begin
                        next_vec       = '{num: cand_num, offset: {2'h0, cand_num, 2'h0}};
                        next_cmd.go    = 1'b1;                  // see (RL9)
                        next_cmd.chain = 1'b1;
                        clr_vec[cand_num] = 1'b1;
                        push     = 1'b1;
                        push_num = cand_num;
                    end else begin
                        next_cmd.restore = 1'b1;                // see (RL10)
                        next_state       = ST_EXIT;
                    end
                end else if (preempt) begin
                    next_vec      = '{num: cand_num, offset: {2'h0, cand_num, 2'h0}}; // see (RL4)
                    next_cmd.save = 1'b1;                       // see (RL10)
                    next_state    = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (stack_done) begin
                    next_cmd.go      = 1'b1;
                    clr_vec[vec.num] = 1'b1;
                    push             = 1'b1;
                    next_state       = ST_RUN;
                end else if (preempt && cand_key.grp < key[vec.num].grp) begin
                    next_vec = '{num: cand_num, offset: {2'h0, cand_num, 2'h0}}; // see (RL9)
                end
            end
            ST_EXIT: begin
                if (unstack_done) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_BOOT_SP;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_BOOT_SP;
            vec   <= '0;
            cmd   <= '0;
        end else begin
            state <= next_state;
            vec   <= next_vec;
            cmd   <= next_cmd;
        end
    end

    // ------------------------------------------------------------
    // Nesting stack
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            depth <= 4'h0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack[i] <= 6'h00;
            end
        end else if (push && pop) begin
            stack[depth-4'h1] <= push_num;
        end else if (push) begin
            stack[depth] <= push_num;
            depth        <= depth + 4'h1;
        end else if (pop) begin
            depth <= depth - 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fetch_sp;
        cmd.fetch && vec.offset == OFS_INIT_SP;
    endsequence

    sequence s_fetch_pc;
        cmd.fetch && cmd.go && vec.offset == OFS_RESET && vec.num == EXC_RESET;
    endsequence

    a_boot_order: assert property ( // see (RL2)
        state == ST_BOOT_SP |=> s_fetch_sp ##1 s_fetch_pc)
        else $error("Boot did not fetch stack pointer then reset vector");

    a_vec_offset: assert property ( // see (RL2) see (RL4)
        (cmd.go || cmd.save) |-> vec.offset == {2'h0, vec.num, 2'h0})
        else $error("Vector offset is not four times exception number");

    a_nmi_first: assert property ( // see (RL3)
        state == ST_RUN && !handler_return && pending[EXC_NMI] && run_grp > KEY_NMI
        |=> state == ST_ENTRY && vec.num == EXC_NMI)
        else $error("Pending NMI was not entered next");

    a_hard_escalate: assert property ( // see (RL3)
        fault_req[0] && !fault_enable[0] |=> pending[EXC_HARD])
        else $error("Disabled fault did not escalate to hard fault");

    a_nmi_cut: assert property ( // see (RL6)
        !nmi_connect |-> !nmi_line)
        else $error("Disconnected NMI still asserted");

    a_no_preempt: assert property ( // see (RL8)
        state == ST_RUN && !handler_return && !(cand_found && cand_key.grp < run_grp)
        |=> state == ST_RUN && !cmd.save)
        else $error("Entry started without higher group priority");

    a_tail_chain: assert property ( // see (RL9)
        state == ST_RUN && handler_return && depth != 4'h0
        |=> (cmd.chain && cmd.go && !cmd.save && state == ST_RUN) ||
            (cmd.restore && state == ST_EXIT))
        else $error("Return neither chained nor restored");

    a_late_arrival: assert property ( // see (RL9)
        state == ST_ENTRY && !stack_done && preempt && cand_key.grp < key[vec.num].grp
        |=> vec.num == $past(cand_num))
        else $error("Better arrival did not take over the entry");

    a_entry_saves: assert property ( // see (RL10)
        $rose(state == ST_ENTRY) |-> cmd.save && !cmd.go)
        else $error("Entry began without a state save");

    a_reserved_quiet: assert property ( // see (RL17)
        irq_src_sel[26] == SRC_FIXED |-> !routed[26])
        else $error("Reserved fixed line raised a request");

endmodule

`default_nettype wire

// File: ivr_controller_test.sv
// Purpose: Bench for ivr_controller
// Assumes: Core model answers every handshake
// Notes:   Inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module ivr_controller_test;
    import ivr_pkg::*;
    logic             clk, resetn, slow, ret_req, irq_mask, nmi_connect;
    logic [31:0]      fixed_irq, fabric_irq, irq_enable;
    logic [15:0]      dma_term_out_low, dma_term_out_high;
    logic [31:0][1:0] irq_src_sel;
    logic [31:0][2:0] irq_level;
    logic [1:0]       prio_split;
    logic [63:0]      nmi_pins;
    logic [5:0]       nmi_pin_sel;
    logic [2:0]       fault_req, fault_enable;
    logic             stack_done, handler_return, unstack_done;
    ivr_vec_t         vec;
    ivr_cmd_t         cmd;
    logic [3:0]       nest_depth;
    int               mismatches, tests_run, cycles;
    // ----
    // Instances
    // ----
    ivr_controller ivr_controller_inst (.clk, .resetn, .fixed_irq, .dma_term_out_low,
        .dma_term_out_high, .fabric_irq, .irq_src_sel, .irq_level, .irq_enable,
        .sys_level('0), .prio_split, .irq_mask, .nmi_pins, .nmi_pin_sel, .nmi_connect,
        .fault_req, .fault_enable, .sys_req(4'h0), .stack_done, .handler_return,
        .unstack_done, .vec, .cmd, .nest_depth);
    ivr_core_model ivr_core_model_inst (.clk, .resetn, .cmd, .vec, .slow, .ret_req,
        .stack_done, .handler_return, .unstack_done);
    // ----
    // Helpers
    // ----
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_vec(string what, ivr_vec_t exp, ivr_vec_t got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic chk_val(string what, logic [3:0] exp, logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic ivr_vec_t v_of(logic [5:0] n);
        return '{n, {2'h0, n, 2'h0}};
    endfunction
    task automatic pulse(int k, int v);
        case (k)
            0: fixed_irq[v] = 1'b1;
            1: if (v < 16) dma_term_out_low[v] = 1'b1; else dma_term_out_high[v-16] = 1'b1;
            default: fabric_irq[v] = 1'b1;
        endcase
        @(negedge clk);
        {fixed_irq, fabric_irq, dma_term_out_low, dma_term_out_high} = '0;
    endtask
    task automatic quiet;
        repeat (8) @(negedge clk);
        chk_val("depth", 4'h0, nest_depth);
    endtask
    task automatic wait_go(logic [5:0] n, logic [3:0] d);
        logic saw;
        saw = 1'b0;
        for (int i = 0; i < 40 && cmd.go !== 1'b1; i++) begin
            saw = saw | (cmd.save === 1'b1);
            @(negedge clk);
        end
        chk_val("save", 4'h1, 4'(saw));
        chk_vec("vec", v_of(n), vec);
        chk_val("depth", d, nest_depth);
        @(negedge clk);
    endtask
    task automatic ret(logic ch, logic [5:0] n);
        ret_req = 1'b1;
        @(negedge clk);
        ret_req = 1'b0;
        for (int i = 0; i < 40 && cmd.chain !== 1'b1 && cmd.restore !== 1'b1; i++)
            @(negedge clk);
        chk_val("chain", 4'(ch), 4'(cmd.chain));
        chk_val("restore", 4'(!ch), 4'(cmd.restore));
        if (ch) chk_vec("vec", v_of(n), vec);
        repeat (10) @(negedge clk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_boot;
        resetn = 1'b0;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        chk_vec("vec", '0, vec);
        chk_val("fetch", 4'h1, 4'(cmd.fetch));
        @(negedge clk);
        chk_vec("vec", v_of(6'h01), vec);
        chk_val("go", 4'h1, 4'(cmd.go));
        repeat (4) @(negedge clk);
        $display("test boot done");
    endtask
    task automatic t_route;
        int v;
        for (int j = 0; j < 2; j++) begin
            v = j ? 20 : 5;
            for (int s = 0; s < 3; s++) begin
                irq_src_sel[v] = 2'(s);
                for (int k = 0; k < 3; k++) if (k != s) pulse(k, v);
                quiet();
                pulse(s, v);
                wait_go(6'(v + 16), 4'h1);
                ret(1'b0, 6'h0);
            end
        end
        irq_src_sel[2] = 2'h0;
        pulse(0, 2);
        quiet();
        $display("test route done");
    endtask
    task automatic t_chain;
        irq_src_sel[3] = 2'h2;
        irq_src_sel[7] = 2'h2;
        irq_src_sel[9] = 2'h2;
        irq_level[3] = 3'h4;
        irq_level[7] = 3'h4;
        irq_level[9] = 3'h1;
        fabric_irq = 32'h0000_0088;
        @(negedge clk);
        fabric_irq = '0;
        wait_go(6'd19, 4'h1);
        pulse(2, 9);
        wait_go(6'd25, 4'h2);
        ret(1'b0, 6'h0);
        ret(1'b1, 6'd23);
        ret(1'b0, 6'h0);
        prio_split = 2'h3;
        pulse(2, 3);
        wait_go(6'd19, 4'h1);
        pulse(2, 9);
        repeat (8) @(negedge clk);
        chk_val("depth", 4'h1, nest_depth);
        ret(1'b1, 6'd25);
        ret(1'b0, 6'h0);
        prio_split = 2'h0;
        slow = 1'b1;
        pulse(2, 7);
        pulse(2, 9);
        wait_go(6'd25, 4'h1);
        ret(1'b1, 6'd23);
        ret(1'b0, 6'h0);
        $display("test chain done");
    endtask
    task automatic t_nmi;
        nmi_pin_sel = 6'h2a;
        nmi_pins[42] = 1'b1;
        @(negedge clk);
        nmi_pins = '0;
        quiet();
        nmi_connect = 1'b1;
        nmi_pins[42] = 1'b1;
        @(negedge clk);
        nmi_pins = '0;
        wait_go(6'd2, 4'h1);
        ret(1'b0, 6'h0);
        fault_enable = 3'h0;
        fault_req = 3'h1;
        @(negedge clk);
        fault_req = 3'h0;
        wait_go(6'd3, 4'h1);
        ret(1'b0, 6'h0);
        $display("test nmi done");
    endtask
    // ----
    // Run
    // ----
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {resetn, slow, ret_req, irq_mask, nmi_connect, fixed_irq, fabric_irq} = '0;
        {dma_term_out_low, dma_term_out_high, irq_src_sel, irq_level, nmi_pins} = '0;
        {prio_split, nmi_pin_sel, fault_req, mismatches, tests_run, cycles} = '0;
        irq_enable = '1;
        fault_enable = 3'h7;
        t_boot();
        t_route();
        t_chain();
        t_nmi();
        close_out();
    end
endmodule
`default_nettype wire

// File: ivr_core_model.sv
// Purpose: Core stand-in answering save, restore and return
// Assumes: Commands are one-cycle pulses
// Notes:   slow stretches the save and restore answers to four cycles
`timescale 1ns/1ps
`default_nettype none
module ivr_core_model
    import ivr_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     resetn,
    input  wire ivr_cmd_t cmd,
    input  wire ivr_vec_t vec,
    input  wire logic     slow,
    input  wire logic     ret_req,
    output logic          stack_done,
    output logic          handler_return,
    output logic          unstack_done
);
    // ----
    // Answers
    // ----
    int s_cnt;
    int u_cnt;
    logic [31:0] entry_pc;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_cnt <= 0;
            u_cnt <= 0;
            entry_pc <= '0;
            handler_return <= 1'b0;
        end else begin
            s_cnt <= cmd.save ? (slow ? 4 : 1) : (s_cnt > 0 ? s_cnt - 1 : 0);
            u_cnt <= cmd.restore ? (slow ? 4 : 1) : (u_cnt > 0 ? u_cnt - 1 : 0);
            // Table word holds the compact-code bit; a clear bit would never return
            if (cmd.go) begin
                entry_pc <= {22'h0, vec.offset} | 32'h1;
            end
            handler_return <= ret_req & entry_pc[0];
        end
    end
    assign stack_done = (s_cnt == 1);
    assign unstack_done = (u_cnt == 1);
endmodule
`default_nettype wire

// File: ivr_pick.sv
// Purpose: Picks the best request by key, lower number on a tie
// Assumes: Keys are stable during the cycle
// Notes:   Purely combinational apart from its check

`timescale 1ns/1ps
`default_nettype none

module ivr_pick
    import ivr_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic [NUM_EXC-1:0]       req,
    input  wire ivr_key_t [NUM_EXC-1:0]   key,
    output logic                          found,
    output logic [5:0]                    num,
    output ivr_key_t                      best
);

    logic better;

    // ------------------------------------------------------------
    // Scan upward, strict compare keeps the lower number
    // ------------------------------------------------------------
    always_comb begin
        found = 1'b0;
        num   = 6'h00;
        best  = '1;
        for (int i = 0; i < NUM_EXC; i++) begin
            if (req[i] && (!found || key[i] < best)) begin // see (RL11)
                found = 1'b1;
                num   = 6'(i);
                best  = key[i];
            end
        end
    end

    always_comb begin
        better = 1'b0;
        for (int i = 0; i < NUM_EXC; i++) begin
            if (req[i] && (key[i] < best || (key[i] == best && 6'(i) < num))) begin
                better = 1'b1;
            end
        end
    end

    a_pick_lowest: assert property ( // see (RL11)
        @(posedge clk) disable iff (!resetn) found |-> !better)
        else $error("Pick is not the best lowest-numbered request");

endmodule

`default_nettype wire

// File: ivr_pkg.sv
// Purpose: Shared constants and types for the interrupt vector routing block
// Assumes: One core clock, asynchronous active-low reset
// Notes:   Keys order exceptions; a lower key wins

package ivr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_SYS     = 16;
    localparam int NUM_IRQ     = 32;
    localparam int NUM_EXC     = 48;
    localparam int LVL_W       = 3;
    localparam int NMI_PIN_W   = 64;
    localparam int STACK_DEPTH = 12;

    // ------------------------------------------------------------
    // Exception numbers and table offsets
    // ------------------------------------------------------------
    localparam logic [5:0] EXC_RESET   = 6'h01;
    localparam logic [5:0] EXC_NMI     = 6'h02;
    localparam logic [5:0] EXC_HARD    = 6'h03;
    localparam logic [5:0] EXC_MEM     = 6'h04;
    localparam logic [5:0] EXC_SVC     = 6'h0b;
    localparam logic [5:0] EXC_DEBUG   = 6'h0c;
    localparam logic [5:0] EXC_PENDSV  = 6'h0e;
    localparam logic [5:0] EXC_SYSTICK = 6'h0f;
    localparam logic [9:0] OFS_INIT_SP = 10'h000;
    localparam logic [9:0] OFS_RESET   = 10'h004;

    // ------------------------------------------------------------
    // Priority keys and masks
    // ------------------------------------------------------------
    localparam logic [4:0]  KEY_RESET     = 5'h00;
    localparam logic [4:0]  KEY_NMI       = 5'h01;
    localparam logic [4:0]  KEY_HARD      = 5'h02;
    localparam logic [4:0]  KEY_PROG_BASE = 5'h03;
    localparam logic [4:0]  KEY_THREAD    = 5'h1f;
    localparam logic [15:0] SYS_PROG_MASK = 16'hd870;
    localparam logic [15:0] SYS_ALWAYS    = 16'h000c;
    localparam logic [31:0] FF_RESERVED   = 32'h0400_0004;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_FIXED  = 2'h0,
        SRC_DMA    = 2'h1,
        SRC_FABRIC = 2'h2
    } ivr_src_t;

    typedef enum logic [4:0] {
        ST_BOOT_SP = 5'h01,
        ST_BOOT_PC = 5'h02,
        ST_RUN     = 5'h04,
        ST_ENTRY   = 5'h08,
        ST_EXIT    = 5'h10
    } ivr_state_t;

    typedef struct packed {
        logic [4:0] grp;
        logic [2:0] sub;
    } ivr_key_t;

    typedef struct packed {
        logic [5:0] num;
        logic [9:0] offset;
    } ivr_vec_t;

    typedef struct packed {
        logic fetch;
        logic save;
        logic restore;
        logic go;
        logic chain;
    } ivr_cmd_t;

    // Split a level into preempting group and ordering sub-level
    function automatic ivr_key_t prog_key(input logic [2:0] lvl, input logic [1:0] split);
        ivr_key_t k;
        k.grp = KEY_PROG_BASE + {2'h0, lvl >> split};
        k.sub = lvl & ~(3'h7 << split);
        return k;
    endfunction

endpackage

// File: ivr_src_sel.sv
// Purpose: Three-way request source select for one vector
// Assumes: Select is static or changes synchronously
// Notes:   Unused code falls back to the fixed line

`timescale 1ns/1ps
`default_nettype none

module ivr_src_sel
    import ivr_pkg::*;
(
    input  wire ivr_src_t sel,
    input  wire logic     fixed_line,
    input  wire logic     dma_line,
    input  wire logic     fabric_line,
    output logic          req
);

    // ------------------------------------------------------------
    // Select
    // ------------------------------------------------------------
    always_comb begin
        case (sel)
            SRC_FIXED:  req = fixed_line;
            SRC_DMA:    req = dma_line;
            SRC_FABRIC: req = fabric_line;
            default:    req = fixed_line;
        endcase
    end

endmodule

`default_nettype wire
